// File: pkg/outdiv_pkg.sv
package outdiv_pkg;

   // register indices; byte address is four times the index
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_CLOCK_OUTPUT_TWO_CTRL = 10'h04C;
   localparam logic [9:0] IDX_LOW_MODE = 10'h04D;
   localparam logic [9:0] IDX_HIGH_SET0 = 10'h04E;
   localparam logic [9:0] IDX_HIGH_SET1 = 10'h04F;
   localparam logic [9:0] IDX_OUT3_CTRL = 10'h050;
   localparam logic [9:0] IDX_SW_CTRL = 10'h060;
   localparam logic [9:0] IDX_STATUS = 10'h061;

   // reset values
   localparam logic [7:0] OUT_CTRL_RST = 8'h00;
   localparam logic [7:0] LOW_MODE_RST = 8'hBB;
   localparam logic [7:0] HIGH_RST = 8'h00;
   localparam logic [2:0] SW_CTRL_RST = 3'h0;

   // output control field positions
   localparam int OEM_LSB = 6;
   localparam int SLEW_LSB = 4;
   localparam int INV_BIT = 2;

   // low/mode register field positions
   localparam int Q1_LSB = 6;
   localparam int PM1_LSB = 4;
   localparam int Q0_LSB = 2;
   localparam int PM0_LSB = 0;

   // software control bit positions
   localparam int SW_ENABLE_BIT = 0;
   localparam int SW_MULTI_BIT = 1;
   localparam int SW_SELECT_BIT = 2;

   // status bit positions
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam int STAT_ON_BIT = 2;
   localparam int STAT_PIN_BIT = 3;

   localparam int DIV_W = 10;

   typedef enum logic [1:0]
   {
      MODE_OFF = 2'b00,
      MODE_BYPASS = 2'b01,
      MODE_DIV_A = 2'b10,
      MODE_DIV_B = 2'b11
   } divide_mode_code_t;

   typedef struct packed
   {
      logic [1:0] output_disable_mode;
      logic [1:0] edge_rate_setting;
      logic output_invert_bit;
   } out_ctrl_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage

// File: hw/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level in and out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed
   {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // first stage feeds only the second stage
   always_comb
   begin
      next_state.first = async_in;
      next_state.second = state.first;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   assign sync_out = state.second;

endmodule // level_sync
`default_nettype wire

// File: hw/ratio_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ratio_divider #(
   parameter int W = 10
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic [W-1:0] ratio,
   // divided clock
   output logic div_clk
);

   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic q;
   } div_state_t;

   div_state_t state;
   div_state_t next_state;
   logic [W-1:0] wrap;

   always_comb
   begin
      next_state = state;
      wrap = '0;
      if (!run || restart)
      begin
         next_state.cnt = '0;
         next_state.q = 1'b0;
      end
      else if (ratio <= W'(1))
      begin
         // fastest case: one toggle per edge, half the source rate
         next_state.cnt = '0;
         next_state.q = ~state.q;
      end
      else
      begin
         wrap = ratio - W'(1);
         next_state.cnt = (state.cnt >= wrap) ? '0 : state.cnt + W'(1);
         // high for the first ratio/2 counts of each period (rounded down), low for the rest
         next_state.q = (next_state.cnt < (ratio >> 1));
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   assign div_clk = state.q;

endmodule // ratio_divider
`default_nettype wire

// File: hw/output_divider_config.sv
//
// Overview of operation
// R1: invert bit flips output polarity, default off
// R2: disabled output tri-states or parks per mode
// R3: two divider/mode copies, one per set
// R4: software enables with nonzero mode both sets; the code checks only the active set's mode, with the pin also required
// R5: software writes zero to reserved control bits
// R6: low/mode at 0x4D, highs 0x4E/0x4F
// R7: selected set drives divider, switches on change
//
`timescale 1ns/1ps
`default_nettype none
module output_divider_config
   import outdiv_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire outdiv_pkg::apb_req_t apb_req,
   output outdiv_pkg::apb_rsp_t apb_rsp,
   // pin from outside, high lets the output run
   input wire logic shutdown_enable_pin,
   // clock output pin
   output logic clock_output_two,
   output logic clock_output_two_oe,
   // neighbouring bank control, held here only
   output logic [7:0] out3_output_control
);

   import outdiv_pkg::*;

   typedef struct packed
   {
      out_ctrl_t clock_output_two_ctrl;
      logic [7:0] low_mode;
      logic [7:0] high_set0;
      logic [7:0] high_set1;
      logic [7:0] out3_ctrl;
      logic [2:0] sw_ctrl;
      logic active_set;
      logic out_level;
      logic out_oe;
      apb_rsp_t rsp;
   } cfg_state_t;

   cfg_state_t state;
   cfg_state_t next_state;

   logic pin_enable;
   logic div_clk;
   logic restart;
   logic run;
   logic output_on;
   logic select_set;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic [1:0] mode_active;
   logic [DIV_W-1:0] ratio0;
   logic [DIV_W-1:0] ratio1;
   logic [DIV_W-1:0] ratio_active;
   logic [DIV_W-1:0] ratio_eff;
   logic [9:0] index;
   logic aligned;
   logic mapped;
   logic [7:0] rd_byte;
   logic [7:0] status;
   logic [7:0] ctrl_byte;

   // pin comes from the board, so two stages before use
   level_sync #(
      .W(1)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(shutdown_enable_pin),
      .sync_out(pin_enable)
   );

   // field unpacking of both configuration sets
   always_comb
   begin
      mode0 = state.low_mode[PM0_LSB +: 2]; // R3
      mode1 = state.low_mode[PM1_LSB +: 2]; // R3
      ratio0 = {state.high_set0, state.low_mode[Q0_LSB +: 2]}; // R6
      ratio1 = {state.high_set1, state.low_mode[Q1_LSB +: 2]}; // R6
   end

   // set 1 only reachable in multi-config mode
   assign select_set = state.sw_ctrl[SW_MULTI_BIT] & state.sw_ctrl[SW_SELECT_BIT];

   // active set values feed the divider
   always_comb
   begin
      if (state.active_set)
      begin
         mode_active = mode1; // R7
         ratio_active = ratio1; // R7
      end
      else
      begin
         mode_active = mode0; // R7
         ratio_active = ratio0; // R7
      end
   end

   // bypass code runs at the fastest rate the divider offers
   always_comb
   begin
      case (divide_mode_code_t'(mode_active))
         MODE_OFF:
            ratio_eff = ratio_active;
         MODE_BYPASS:
            ratio_eff = DIV_W'(1);
         MODE_DIV_A,
         MODE_DIV_B:
            ratio_eff = ratio_active;
         default:
            ratio_eff = ratio_active;
      endcase
   end

   // a zero code in the active set stops dividing
   assign run = (mode_active != MODE_OFF); // R4

   // restart on a set change avoids a runt from mixed settings
   assign restart = (state.active_set != select_set); // R7

   ratio_divider #(
      .W(DIV_W)
   ) u_divider (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .restart(restart),
      .ratio(ratio_eff),
      .div_clk(div_clk)
   );

   // the pin only counts once it has passed both synchroniser stages
   assign output_on = state.sw_ctrl[SW_ENABLE_BIT] & pin_enable & run; // R2 R4

   // bus decode
   assign index = apb_req.paddr[ADDR_W-1:2];
   // a byte offset inside a word is refused, not folded onto it
   assign aligned = (apb_req.paddr[1:0] == 2'h0);

   always_comb
   begin
      mapped = aligned;
      case (index)
         IDX_CLOCK_OUTPUT_TWO_CTRL,
         IDX_LOW_MODE,
         IDX_HIGH_SET0,
         IDX_HIGH_SET1,
         IDX_OUT3_CTRL,
         IDX_SW_CTRL,
         IDX_STATUS:
            mapped = aligned;
         default:
            mapped = 1'b0;
      endcase
   end

   // reserved bits 3, 1, 0 always read back as zero
   always_comb
   begin
      ctrl_byte = 8'h00;
      ctrl_byte[OEM_LSB +: 2] = state.clock_output_two_ctrl.output_disable_mode;
      ctrl_byte[SLEW_LSB +: 2] = state.clock_output_two_ctrl.edge_rate_setting;
      ctrl_byte[INV_BIT] = state.clock_output_two_ctrl.output_invert_bit;
   end

   // status is a live view, never stored, so it cannot go stale
   always_comb
   begin
      status = 8'h00;
      status[STAT_ACTIVE_BIT] = state.active_set;
      status[STAT_RUN_BIT] = run;
      status[STAT_ON_BIT] = output_on;
      status[STAT_PIN_BIT] = pin_enable;
   end

   always_comb
   begin
      case (index)
         IDX_CLOCK_OUTPUT_TWO_CTRL:
            rd_byte = ctrl_byte;
         IDX_LOW_MODE:
            rd_byte = state.low_mode;
         IDX_HIGH_SET0:
            rd_byte = state.high_set0;
         IDX_HIGH_SET1:
            rd_byte = state.high_set1;
         IDX_OUT3_CTRL:
            rd_byte = state.out3_ctrl;
         IDX_SW_CTRL:
            rd_byte = {5'h00, state.sw_ctrl};
         IDX_STATUS:
            rd_byte = status;
         // unmapped reads return zero; the error flag tells them apart
         default:
            rd_byte = 8'h00;
      endcase
   end

   always_comb
   begin
      next_state = state;

      // set selection takes effect one edge after it changes
      next_state.active_set = select_set; // R7

      // output stage: divided clock with polarity, or disable action
      if (output_on)
      begin
         next_state.out_oe = 1'b1;
         next_state.out_level = div_clk ^ state.clock_output_two_ctrl.output_invert_bit; // R1
      end
      // park levels ignore the invert bit; only the running clock is flipped
      else if (!state.clock_output_two_ctrl.output_disable_mode[1])
      begin
         next_state.out_oe = 1'b0; // R2
         next_state.out_level = 1'b0;
      end
      else
      begin
         next_state.out_oe = 1'b1; // R2
         next_state.out_level = state.clock_output_two_ctrl.output_disable_mode[0]; // R2
      end

      // bus: pready raised in the second access cycle, write at its sample edge
      if (state.rsp.pready)
      begin
         next_state.rsp.pready = 1'b0;
         next_state.rsp.pslverr = 1'b0;
         next_state.rsp.prdata = 32'h0000_0000;
         if (apb_req.psel && apb_req.penable && apb_req.pwrite && mapped)
         begin
            case (index)
               IDX_CLOCK_OUTPUT_TWO_CTRL:
               begin
                  // reserved positions are dropped, not stored
                  next_state.clock_output_two_ctrl.output_disable_mode = apb_req.pwdata[OEM_LSB +: 2];
                  next_state.clock_output_two_ctrl.edge_rate_setting = apb_req.pwdata[SLEW_LSB +: 2];
                  next_state.clock_output_two_ctrl.output_invert_bit = apb_req.pwdata[INV_BIT]; // R1
               end
               IDX_LOW_MODE:
                  next_state.low_mode = apb_req.pwdata[7:0]; // R6
               IDX_HIGH_SET0:
                  next_state.high_set0 = apb_req.pwdata[7:0]; // R6
               IDX_HIGH_SET1:
                  next_state.high_set1 = apb_req.pwdata[7:0]; // R6
               IDX_OUT3_CTRL:
                  next_state.out3_ctrl = apb_req.pwdata[7:0];
               IDX_SW_CTRL:
                  next_state.sw_ctrl = apb_req.pwdata[2:0];
               // status is a read-only view: the write is answered and dropped
               IDX_STATUS:
                  next_state.sw_ctrl = state.sw_ctrl;
               default:
                  next_state.sw_ctrl = state.sw_ctrl;
            endcase
         end
      end
      else if (apb_req.psel && apb_req.penable)
      begin
         next_state.rsp.pready = 1'b1;
         next_state.rsp.pslverr = ~mapped;
         next_state.rsp.prdata = (mapped && !apb_req.pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // reset branch holds constants only, field by field, so none is missed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state.clock_output_two_ctrl.output_disable_mode <= OUT_CTRL_RST[OEM_LSB +: 2]; // R2
         state.clock_output_two_ctrl.edge_rate_setting <= OUT_CTRL_RST[SLEW_LSB +: 2];
         state.clock_output_two_ctrl.output_invert_bit <= OUT_CTRL_RST[INV_BIT]; // R1
         state.low_mode <= LOW_MODE_RST; // R3 R6
         state.high_set0 <= HIGH_RST; // R6
         state.high_set1 <= HIGH_RST; // R6
         state.out3_ctrl <= OUT_CTRL_RST;
         state.sw_ctrl <= SW_CTRL_RST;
         state.active_set <= 1'b0;
         state.out_level <= 1'b0;
         state.out_oe <= 1'b0;
         state.rsp <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign apb_rsp = state.rsp;
   assign clock_output_two = state.out_level;
   assign clock_output_two_oe = state.out_oe;
   assign out3_output_control = state.out3_ctrl;

endmodule // output_divider_config
`default_nettype wire

// File: test/output_divider_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module output_divider_config_asserts
   import outdiv_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched ports
   input wire outdiv_pkg::apb_req_t apb_req,
   input wire outdiv_pkg::apb_rsp_t apb_rsp,
   input wire logic shutdown_enable_pin,
   input wire logic clock_output_two,
   input wire logic clock_output_two_oe,
   input wire logic [7:0] out3_output_control
);
   logic [1:0] dis_mode;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of the disable-mode field, taken at the accepting edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dis_mode <= 2'h0;
      else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 12'h130)
         dis_mode <= apb_req.pwdata[7:6];
   end
   sequence s_wait;
      apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence
   // five samples cover the pin synchroniser plus the output flop
   sequence s_shut(logic [1:0] m);
      (!shutdown_enable_pin && dis_mode == m)[*5];
   endsequence
   property p_answer;
      s_wait |=> apb_rsp.pready;
   endproperty
   property p_pulse;
      apb_rsp.pready |=> !apb_rsp.pready;
   endproperty
   property p_unmapped;
      s_wait and apb_req.paddr == 12'h1C0 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
   endproperty
   property p_tri;
      s_shut(2'h0) or s_shut(2'h1) |-> !clock_output_two_oe && !clock_output_two;
   endproperty
   property p_low;
      s_shut(2'h2) |-> clock_output_two_oe && !clock_output_two;
   endproperty
   property p_high;
      s_shut(2'h3) |-> clock_output_two_oe && clock_output_two;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer one cycle after access");
   a_pulse: assert property (p_pulse) else $error("pready held past one cycle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   a_tri: assert property (p_tri) else $error("disabled output not tri-stated");
   a_low: assert property (p_low) else $error("disabled output not parked low");
   a_high: assert property (p_high) else $error("disabled output not parked high");
endmodule // output_divider_config_asserts
bind output_divider_config output_divider_config_asserts u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .shutdown_enable_pin(shutdown_enable_pin),
   .clock_output_two(clock_output_two),
   .clock_output_two_oe(clock_output_two_oe),
   .out3_output_control(out3_output_control)
);
`default_nettype wire

// File: test/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model
   import outdiv_pkg::*;
(
   // clock
   input wire logic pclk,
   // register bus
   output var outdiv_pkg::apb_req_t apb_req,
   input wire outdiv_pkg::apb_rsp_t apb_rsp
);
   initial apb_req = '0;
   task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d,
      output logic [7:0] q, output logic e);
      @(posedge pclk);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= w;
      apb_req.paddr <= {i, 2'h0};
      apb_req.pwdata <= {24'h0, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do
         @(posedge pclk);
      while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata[7:0];
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      // stale address and data must not look valid once released
      apb_req.paddr <= ~apb_req.paddr;
      apb_req.pwdata <= ~apb_req.pwdata;
   endtask
endmodule // apb_host_model
`default_nettype wire

// File: test/tb_output_divider_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_output_divider_config;
   import outdiv_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic pin = 1'b0;
   apb_req_t req;
   apb_rsp_t rsp;
   logic co, oe, e;
   logic [7:0] o3, q;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #5 pclk = ~pclk;
   output_divider_config u_dut (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(req),
      .apb_rsp(rsp),
      .shutdown_enable_pin(pin),
      .clock_output_two(co),
      .clock_output_two_oe(oe),
      .out3_output_control(o3)
   );
   apb_host_model u_host (
      .pclk(pclk),
      .apb_req(req),
      .apb_rsp(rsp)
   );
   task automatic complete_run();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      u_host.xfer(1'b1, i, d, q, e);
   endtask
   task automatic rdc(input logic [9:0] i, input logic [7:0] x);
      u_host.xfer(1'b0, i, 8'h00, q, e);
      chk(q, x);
   endtask
   // skips a few periods so a just-written setting has settled
   task automatic measure(input logic [7:0] hi, input logic [7:0] lo);
      int h;
      int l;
      h = 0;
      l = 0;
      repeat (24) @(posedge pclk);
      while (co !== 1'b0) @(posedge pclk);
      while (co !== 1'b1) @(posedge pclk);
      while (co === 1'b1)
      begin
         h++;
         @(posedge pclk);
      end
      while (co === 1'b0)
      begin
         l++;
         @(posedge pclk);
      end
      chk(8'(h), hi);
      chk(8'(l), lo);
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk({7'h0, oe}, 8'h00);
      rdc(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'h00);
      rdc(IDX_LOW_MODE, 8'hBB);
      rdc(IDX_HIGH_SET0, 8'h00);
      rdc(IDX_HIGH_SET1, 8'h00);
      rdc(IDX_OUT3_CTRL, 8'h00);
      rdc(IDX_SW_CTRL, 8'h00);
      rdc(IDX_STATUS, 8'h02);
      rdc(10'h070, 8'h00);
      chk({7'h0, e}, 8'h01);
      wr(IDX_OUT3_CTRL, 8'hA5);
      @(posedge pclk);
      chk(o3, 8'hA5);
      wr(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'hF4);
      rdc(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'hF4);
      for (int m = 0; m < 4; m++)
      begin
         wr(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'(m << 6));
         repeat (4) @(posedge pclk);
         chk({6'h0, oe, co}, {6'h0, m[1], m[1] & m[0]});
      end
      pin <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({6'h0, oe, co}, 8'h03);
      wr(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'h00);
      wr(IDX_SW_CTRL, 8'h01);
      measure(8'h01, 8'h01);
      wr(IDX_LOW_MODE, 8'hA7);
      wr(IDX_HIGH_SET0, 8'h01);
      measure(8'h02, 8'h03);
      wr(IDX_CLOCK_OUTPUT_TWO_CTRL, 8'h04);
      measure(8'h03, 8'h02);
      wr(IDX_HIGH_SET1, 8'h02);
      wr(IDX_SW_CTRL, 8'h07);
      measure(8'h05, 8'h05);
      rdc(IDX_STATUS, 8'h0F);
      wr(IDX_SW_CTRL, 8'h03);
      measure(8'h03, 8'h02);
      wr(IDX_LOW_MODE, 8'hB5);
      measure(8'h01, 8'h01);
      wr(IDX_LOW_MODE, 8'hB4);
      repeat (4) @(posedge pclk);
      chk({7'h0, oe}, 8'h00);
      rdc(IDX_STATUS, 8'h08);
      complete_run();
   end
endmodule // tb_output_divider_config
`default_nettype wire
